// *** design/flash_serial_phase_sequencer.sv ***
// host controller sequencing instruction, address, latency, data phases
// assumes one ahb-lite master, io pins resolved outside, device in mode 0
//
// Behaviour
// (RQ1) single input: reset high, select low, drive
// (RQ2) after single input follow command's next phase
// (RQ3) latency count comes from latency code field
// (RQ4) single latency: host floats serial input
// (RQ5) write protect pin is don't-care to device
// (RQ6) single output: read serial output until deselect
// (RQ7) dual input: two bits per clock, lines 0-1
// (RQ8) release dual lines throughout dual latency
// (RQ9) dual latency: lines idle, then dual output
// (RQ10) dual output: two bits per clock sampled
// (RQ11) quad input: four bits per clock, four-wire too
// (RQ12) four-wire program: raise select after data
// (RQ13) quad latency if configured, else quad output
// (RQ14) release all four lines during quad latency
// (RQ15) quad output: four bits per clock sampled
// (RQ16) ddr input: nibble on each clock edge
// (RQ17) host never drives lines in ddr latency
// (RQ18) learning pattern only in last latency cycles
// (RQ19) refuse learning pattern below five latency cycles
// (RQ20) ddr output: nibble sampled on each edge
// (RQ21) four-wire mode sends instruction four bits wide
// (RQ22) quad widths use protect and reset as data
// (RQ23) select high means standby, lines idle
// (RQ24) raising select ends command, lines released
// (RQ25) latency code used directly as cycle count; in ddr the code treats code 0 as one cycle
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module flash_serial_phase_sequencer #(
  parameter int SCK_HALF = 6                  // sys clocks per sck half
) (
  input  wire logic                        clk_sys,   // 10 mhz clock
  input  wire logic                        nrst,      // sync reset, low
  input  wire logic                        hsel,      // slave select
  input  wire logic [31:0]                 haddr,     // byte address
  input  wire logic [1:0]                  htrans,    // transfer type
  input  wire logic                        hwrite,    // write access
  input  wire logic [2:0]                  hsize,     // word only
  input  wire logic [31:0]                 hwdata,    // write data
  input  wire logic                        hready,    // bus ready
  output logic                             hreadyout, // ready except in reset
  output logic [31:0]                      hrdata,    // read data
  output logic                             hresp,     // always okay
  output flash_phase_pkg::flash_pins_t     pins,      // flash pins
  input  wire logic [3:0]                  io_in      // data line levels
);
  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

  flash_phase_pkg::phase_t state_r;
  logic [1:0]  wid_r;
  logic        rd_r;
  logic        qcmd_r;
  logic        addr_en_r;
  logic [3:0]  lat_r;
  logic        lp_r;
  logic [2:0]  nbytes_r;
  logic [7:0]  instr_r;
  logic [7:0]  modeb_r;
  logic [23:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [31:0] pat_r;
  logic [31:0] rx_r;
  logic [63:0] sr_r;
  logic [5:0]  rem_r;
  logic [7:0]  cnt_r;
  logic        sck_r;
  logic        done_r;
  logic        err_r;
  logic [3:0]  io_s1_r;
  logic [3:0]  io_s2_r;
  logic        wr_pend_r;
  logic [7:0]  waddr_r;

  // effective width: four-wire mode turns single phases quad
  logic [1:0] ew;
  logic       run;
  logic       ddr_ph;
  logic [2:0] lanes;
  logic       wrap;
  logic       mid;
  logic       shift_ev;
  logic       samp_ev;
  logic       step_ev;
  logic       turn_ev;
  logic [3:0] lat_eff;
  logic [5:0] abeats;
  logic [5:0] dbeats;
  logic       go_wr;
  logic       start_ok;
  logic [63:0] sr_load;
  flash_phase_pkg::phase_t fol_st;
  logic [5:0] fol_rem;

  assign ew = (qcmd_r && wid_r != flash_phase_pkg::W_DDR)
              ? flash_phase_pkg::W_QUAD : wid_r; // RQ11 RQ21
  assign run = state_r == flash_phase_pkg::st_cmd
            || state_r == flash_phase_pkg::st_addr
            || state_r == flash_phase_pkg::st_lat
            || state_r == flash_phase_pkg::st_data;
  assign ddr_ph = ew == flash_phase_pkg::W_DDR && run
               && state_r != flash_phase_pkg::st_cmd; // RQ16 RQ20
  assign wrap = run && cnt_r == HALF_LAST;
  assign mid = run && cnt_r == flash_phase_pkg::MID_PHASE;
  // ddr uses both clock halves, sdr only the low one
  assign shift_ev = mid && (ddr_ph || !sck_r)
                 && state_r != flash_phase_pkg::st_lat;
  // sample just before the edge: the synchroniser adds two cycles
  assign samp_ev = wrap && (ddr_ph || sck_r) && rd_r
                && state_r == flash_phase_pkg::st_data;
  // last read address beat taken: let go before the device's next fall,
  // else a zero-latency read has both ends driving for two clocks
  assign turn_ev = state_r == flash_phase_pkg::st_addr && rd_r && !ddr_ph
                && rem_r == 6'h01
                && (sck_r ? cnt_r >= flash_phase_pkg::MID_PHASE
                          : cnt_r <= flash_phase_pkg::MID_PHASE); // RQ14
  assign lat_eff = (ew == flash_phase_pkg::W_DDR && lat_r == 4'h0)
                   ? 4'h1 : lat_r; // RQ3 RQ25

  // lanes in use by the current phase
  always_comb begin
    lanes = 3'h1;
    if (state_r == flash_phase_pkg::st_start
        || state_r == flash_phase_pkg::st_cmd) begin
      lanes = qcmd_r ? 3'h4 : 3'h1; // RQ21
    end else begin
      case (ew)
        flash_phase_pkg::W_DUAL:   lanes = 3'h2; // RQ7
        flash_phase_pkg::W_QUAD:   lanes = 3'h4; // RQ11
        flash_phase_pkg::W_DDR:    lanes = 3'h4; // RQ16
        default:                   lanes = 3'h1; // RQ1
      endcase
    end
  end

  // beats per phase; mode byte only on wide reads
  always_comb begin
    abeats = flash_phase_pkg::ADDR_BITS;
    if (rd_r && ew != flash_phase_pkg::W_SINGLE) begin
      abeats = flash_phase_pkg::ADDR_BITS + flash_phase_pkg::MODE_BITS;
    end
    dbeats = {nbytes_r, 3'h0};
    case (ew)
      flash_phase_pkg::W_DUAL: begin
        abeats = abeats >> 1;
        dbeats = dbeats >> 1;
      end
      flash_phase_pkg::W_SINGLE: begin
        abeats = abeats;
      end
      default: begin
        abeats = abeats >> 2;
        dbeats = dbeats >> 2;
      end
    endcase
  end

  // which phase follows the current one
  always_comb begin
    fol_st = flash_phase_pkg::st_end;
    fol_rem = 6'h00;
    if (state_r == flash_phase_pkg::st_cmd && addr_en_r) begin
      fol_st = flash_phase_pkg::st_addr; // RQ2
      fol_rem = abeats;
    end else if (state_r == flash_phase_pkg::st_addr && rd_r
                 && lat_eff != 4'h0) begin
      fol_st = flash_phase_pkg::st_lat; // RQ9 RQ13 RQ17
      fol_rem = {2'h0, lat_eff}; // RQ25
    end else if (state_r != flash_phase_pkg::st_data
                 && nbytes_r != 3'h0) begin
      fol_st = flash_phase_pkg::st_data; // RQ2 RQ13
      fol_rem = dbeats;
    end
  end

  always_comb begin
    case (state_r)
      flash_phase_pkg::st_lat:  step_ev = mid && !sck_r;
      flash_phase_pkg::st_data: step_ev = rd_r ? samp_ev : shift_ev;
      default:                  step_ev = shift_ev;
    endcase
  end

  assign go_wr = wr_pend_r && waddr_r == flash_phase_pkg::OFF_CTRL
              && hwdata[flash_phase_pkg::CB_GO];
  // pattern needs a free turnaround cycle first
  assign start_ok = go_wr && state_r == flash_phase_pkg::st_idle
    && !(lp_r && ew == flash_phase_pkg::W_DDR
         && lat_r < flash_phase_pkg::LP_MIN_LAT); // RQ19
  assign sr_load = !addr_en_r ? {instr_r, wdata_r, 24'h0}
    : (rd_r && ew != flash_phase_pkg::W_SINGLE)
      ? {instr_r, addr_r, modeb_r, 24'h0}
      : {instr_r, addr_r, wdata_r};

  // two-flop synchroniser on the data lines
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // sck divider, only toggling while selected
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (state_r == flash_phase_pkg::st_start) begin
      cnt_r <= flash_phase_pkg::MID_PHASE + 8'h01;
      sck_r <= 1'b0;
    end else if (run) begin
      cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
      sck_r <= wrap ? !sck_r : sck_r;
    end else begin
      cnt_r <= 8'h00;
      sck_r <= 1'b0; // RQ23
    end
  end

  // phase sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= flash_phase_pkg::st_idle;
      rem_r <= 6'h00;
    end else begin
      case (state_r)
        flash_phase_pkg::st_idle: begin
          if (start_ok) begin
            state_r <= flash_phase_pkg::st_start;
            rem_r <= qcmd_r ? (flash_phase_pkg::INSTR_BITS >> 2)
                            : flash_phase_pkg::INSTR_BITS;
          end
        end
        flash_phase_pkg::st_start: state_r <= flash_phase_pkg::st_cmd;
        flash_phase_pkg::st_end:   state_r <= flash_phase_pkg::st_idle;
        default: begin
          if (step_ev && rem_r == 6'h01) begin
            state_r <= fol_st; // RQ6 RQ10 RQ12 RQ15 RQ24
            rem_r <= fol_rem;
          end else if (step_ev) begin
            rem_r <= rem_r - 6'h01;
          end
        end
      endcase
    end
  end

  // outbound shifter, msb first, top lanes leave first
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sr_r <= 64'h0;
    end else if (start_ok) begin
      sr_r <= sr_load;
    end else if (shift_ev) begin
      case (lanes)
        3'h4:    sr_r <= {sr_r[59:0], 4'h0};
        3'h2:    sr_r <= {sr_r[61:0], 2'h0};
        default: sr_r <= {sr_r[62:0], 1'b0};
      endcase
    end
  end

  // inbound data and learning pattern capture
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_r <= flash_phase_pkg::RST_WORD;
      rdata_r <= flash_phase_pkg::RST_WORD;
      pat_r <= flash_phase_pkg::RST_WORD;
    end else begin
      if (samp_ev) begin
        case (lanes)
          3'h4:    rx_r <= {rx_r[27:0], io_s2_r}; // RQ15 RQ20
          3'h2:    rx_r <= {rx_r[29:0], io_s2_r[1:0]}; // RQ10
          default: rx_r <= {rx_r[30:0], io_s2_r[1]}; // RQ6
        endcase
      end
      if (state_r == flash_phase_pkg::st_end && rd_r) begin
        rdata_r <= rx_r;
      end
      // keeps the last eight nibbles, the pattern window
      if (wrap && ddr_ph && lp_r
          && state_r == flash_phase_pkg::st_lat) begin
        pat_r <= {pat_r[27:0], io_s2_r}; // RQ18
      end
    end
  end

  // pin drivers; protect and reset held high unless used as data
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pins <= '{sck: 1'b0, cs_n: 1'b1,
                io_o: flash_phase_pkg::IDLE_IO,
                io_oe: flash_phase_pkg::IDLE_IO};
    end else begin
      pins.sck <= sck_r;
      pins.cs_n <= !(run || state_r == flash_phase_pkg::st_start);
      pins.io_o <= flash_phase_pkg::IDLE_IO; // RQ1 RQ5
      pins.io_oe <= (lanes == 3'h4 && run) ? 4'h0
                    : flash_phase_pkg::IDLE_IO; // RQ22 RQ23 RQ24
      if ((state_r == flash_phase_pkg::st_start
          || state_r == flash_phase_pkg::st_cmd
          || state_r == flash_phase_pkg::st_addr
          || (state_r == flash_phase_pkg::st_data && !rd_r))
          && !turn_ev) begin // RQ14
        case (lanes)
          3'h4: begin
            pins.io_o <= sr_r[63:60]; // RQ11
            pins.io_oe <= 4'hf;
          end
          3'h2: begin
            pins.io_o <= {2'h3, sr_r[63:62]}; // RQ7
            pins.io_oe <= 4'hf;
          end
          default: begin
            pins.io_o <= {3'h6, sr_r[63]}; // RQ1
            pins.io_oe <= 4'hd;
          end
        endcase
      end
      // latency and read data: data lines left floating
      // RQ4 RQ8 RQ14 RQ17
    end
  end

  // ahb-lite slave, zero wait states
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      hrdata <= flash_phase_pkg::RST_WORD;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= hsel && htrans[1] && hready && hwrite;
      waddr_r <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          flash_phase_pkg::OFF_CTRL:
            hrdata <= {13'h0, nbytes_r, 3'h0, lp_r, lat_r, 2'h0,
                       addr_en_r, qcmd_r, rd_r, wid_r, 1'b0};
          flash_phase_pkg::OFF_CMD:     hrdata <= {16'h0, modeb_r, instr_r};
          flash_phase_pkg::OFF_ADDR:    hrdata <= {8'h0, addr_r};
          flash_phase_pkg::OFF_WDATA:   hrdata <= wdata_r;
          flash_phase_pkg::OFF_RDATA:   hrdata <= rdata_r;
          flash_phase_pkg::OFF_STATUS:
            hrdata <= {29'h0, err_r, done_r,
                       state_r != flash_phase_pkg::st_idle};
          flash_phase_pkg::OFF_PATTERN: hrdata <= pat_r;
          default:                      hrdata <= flash_phase_pkg::RST_WORD;
        endcase
      end
    end
  end

  // configuration writes, ignored while a command runs
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {wid_r, rd_r, qcmd_r, addr_en_r, lat_r, lp_r, nbytes_r} <= '0;
      {instr_r, modeb_r, addr_r} <= '0;
      wdata_r <= flash_phase_pkg::RST_WORD;
    end else if (wr_pend_r && state_r == flash_phase_pkg::st_idle) begin
      case (waddr_r)
        flash_phase_pkg::OFF_CTRL: begin
          wid_r <= hwdata[flash_phase_pkg::CB_WID +: 2];
          rd_r <= hwdata[flash_phase_pkg::CB_READ];
          qcmd_r <= hwdata[flash_phase_pkg::CB_QCMD];
          addr_en_r <= hwdata[flash_phase_pkg::CB_ADDR_EN];
          lat_r <= hwdata[flash_phase_pkg::CB_LAT +: 4]; // RQ3
          lp_r <= hwdata[flash_phase_pkg::CB_LP];
          nbytes_r <= hwdata[flash_phase_pkg::CB_BYTES +: 3];
        end
        flash_phase_pkg::OFF_CMD: begin
          instr_r <= hwdata[7:0];
          modeb_r <= hwdata[15:8];
        end
        flash_phase_pkg::OFF_ADDR:  addr_r <= hwdata[23:0];
        flash_phase_pkg::OFF_WDATA: wdata_r <= hwdata;
        default:                    addr_r <= addr_r;
      endcase
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      done_r <= (state_r == flash_phase_pkg::st_end)
             || (done_r && !(wr_pend_r
                 && waddr_r == flash_phase_pkg::OFF_STATUS
                 && hwdata[flash_phase_pkg::SB_DONE]));
      err_r <= (go_wr && !start_ok
                && state_r == flash_phase_pkg::st_idle) // RQ19
            || (err_r && !(wr_pend_r
                && waddr_r == flash_phase_pkg::OFF_STATUS
                && hwdata[flash_phase_pkg::SB_ERR]));
    end
  end
endmodule

// *** design/flash_phase_pkg.sv ***
// constants, types and register map of the flash phase sequencer host
// assumes a single-slave ahb-lite bus and a flash device on the pins
package flash_phase_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CMD     = 8'h04;
  localparam logic [7:0] OFF_ADDR    = 8'h08;
  localparam logic [7:0] OFF_WDATA   = 8'h0c;
  localparam logic [7:0] OFF_RDATA   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_PATTERN = 8'h18;
  // control register field positions
  localparam int CB_GO      = 0;
  localparam int CB_WID     = 1;
  localparam int CB_READ    = 3;
  localparam int CB_QCMD    = 4;
  localparam int CB_ADDR_EN = 5;
  localparam int CB_LAT     = 8;
  localparam int CB_LP      = 12;
  localparam int CB_BYTES   = 16;
  // status register field positions
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_ERR  = 2;
  // transfer width codes
  localparam logic [1:0] W_SINGLE = 2'h0;
  localparam logic [1:0] W_DUAL   = 2'h1;
  localparam logic [1:0] W_QUAD   = 2'h2;
  localparam logic [1:0] W_DDR    = 2'h3;
  // frame field sizes in bits
  localparam logic [5:0] INSTR_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam logic [5:0] MODE_BITS  = 6'h08;
  // least latency that leaves a turnaround before the learning pattern
  localparam logic [3:0] LP_MIN_LAT = 4'h5;
  // divider phase at which the host moves its output bits
  localparam logic [7:0] MID_PHASE = 8'h01;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  IDLE_IO  = 4'hc;

  typedef enum {
    st_idle, st_start, st_cmd, st_addr, st_lat, st_data, st_end
  } phase_t;

  // flash-facing pins
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } flash_pins_t;
endpackage

// *** tb/flash_phase_checker.sv ***
// assertions on the bus answer and flash pins of the phase sequencer
// assumes it is bound into the sequencer and sees only its ports
`timescale 1ns/100ps
module flash_phase_checker #(
  parameter int SCK_HALF = 6                 // sys clocks per sck half
) (
  input wire logic                   clk_sys,   // system clock
  input wire logic                   nrst,      // sync reset, low
  input wire logic                   hreadyout, // bus ready out
  input wire logic                   hresp,     // bus response
  input flash_phase_pkg::flash_pins_t pins      // flash pins
);
  logic       sck_d; // sck one clock ago
  logic       oe0_d; // io0 enable one clock ago
  logic       rel_r; // host gave io0/io1 up in this frame
  logic [7:0] hcnt;  // clocks since last sck edge

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // delayed copies, used to spot edges
  always_ff @(posedge clk_sys) begin
    sck_d <= nrst & pins.sck;
    oe0_d <= nrst & pins.io_oe[0];
  end
  // saturating, so a long idle never wraps into a false match
  always_ff @(posedge clk_sys) begin
    if (!nrst || pins.sck != sck_d) hcnt <= 8'h00;
    else if (hcnt != 8'hff) hcnt <= hcnt + 8'h01;
  end
  // once released inside a frame the lines must stay released
  always_ff @(posedge clk_sys) begin
    if (!nrst || pins.cs_n) rel_r <= 1'b0;
    else if (oe0_d && !pins.io_oe[0]) rel_r <= 1'b1;
  end

  sequence s_idle3;
    pins.cs_n[*3];
  endsequence
  sequence s_gap;
    pins.cs_n[*2];
  endsequence

  a_okay_only: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_zero_wait: assert property ($past(nrst) |-> hreadyout)
    else $error("hreadyout low outside reset");
  a_idle_clock: assert property (pins.cs_n |-> !pins.sck)
    else $error("sck high while deselected");
  a_idle_lines: assert property (
    s_idle3 |-> pins.io_oe[1:0] == 2'b00)
    else $error("io0/io1 driven in standby");
  a_reset_high: assert property (
    pins.io_oe == 4'hd |-> pins.io_o[3:2] == 2'b11)
    else $error("reset or protect low in single input");
  a_keep_release: assert property (
    rel_r && !pins.cs_n |-> pins.io_oe[1:0] == 2'b00)
    else $error("host drove data lines after turnaround");
  a_sck_half: assert property (sck_d && !pins.sck |-> hcnt == 8'(SCK_HALF - 1))
    else $error("sck high phase wrong length");
  a_cs_gap: assert property ($rose(pins.cs_n) |-> s_gap)
    else $error("chip select gap too short");
endmodule

bind flash_serial_phase_sequencer flash_phase_checker #(.SCK_HALF(SCK_HALF))
  i_flash_phase_checker (.clk_sys(clk_sys), .nrst(nrst),
  .hreadyout(hreadyout), .hresp(hresp), .pins(pins));

// *** tb/flash_device_model.sv ***
// behavioural serial flash: input, latency, pattern and output phases
// assumes the bench resolves the io wires and sets the command shape
`timescale 1ns/100ps
module flash_device_model #(
  parameter logic [31:0] RD_WORD = 32'hc3a5_96e1, // read data, arbitrary
  parameter logic [31:0] LP_WORD = 32'h5a3c_e187  // learning pattern
) (
  input  wire logic        sck,     // serial clock
  input  wire logic        cs_n,    // chip select, low
  input  wire logic [3:0]  io,      // resolved data lines
  input  wire logic [1:0]  width,   // width code of the command
  input  wire logic        qcmd,    // four-wire command mode
  input  wire logic        rd,      // read command
  input  wire logic [6:0]  in_bits, // host bits before latency
  input  wire logic [3:0]  lat,     // latency code
  input  wire logic        lp,      // learning pattern on
  output logic      [3:0]  dev_o,   // driven levels
  output logic      [3:0]  dev_oe,  // driven enables
  output logic      [63:0] rx       // bits received, last in lsb
);
  logic        sk;  // sck before this event
  logic        ddr; // double data rate command
  logic [31:0] dq;  // read data left to send
  logic [31:0] pq;  // pattern left to send
  int          got; // input bits taken
  int          fl;  // falls since input ended
  int          ln;  // lanes of this step
  int          t;   // fall that starts the data

  initial begin
    {dev_o, dev_oe, rx, sk, dq, pq} = '0;
    got = 0;
    fl = 0;
  end
  // one process for all edges so select and clock never race
  always @(posedge sck or negedge sck or posedge cs_n or negedge cs_n) begin
    ddr = (width == flash_phase_pkg::W_DDR);
    t = ddr ? ((lat == 4'h0) ? 1 : int'(lat)) : int'(lat) + 1;
    if (cs_n !== 1'b0) begin
      dev_oe = 4'h0;
      got = 0;
      fl = 0;
      dq = RD_WORD;
      pq = LP_WORD;
    end else if (sck === sk) begin
      rx = 64'h0;
    end else if (got < in_bits) begin
      // protect pin is only a lane when the width or four-wire mode asks for it
      ln = (got < 8) ? (qcmd ? 4 : 1)
         : (qcmd || width[1]) ? 4 : width[0] ? 2 : 1;
      if (sck || (ddr && got > 8)) begin
        rx = (rx << ln) | 64'(io & 4'((1 << ln) - 1));
        got = got + ln;
      end
    end else if (rd) begin
      if (!sck) fl = fl + 1;
      if (fl >= t && (ddr || !sck)) begin
        ln = width[1] ? 4 : width[0] ? 2 : 1;
        dev_oe = (ln == 1) ? 4'h2 : 4'((1 << ln) - 1);
        dev_o = (ln == 1) ? {2'b00, dq[31], 1'b0} : 4'(dq >> (32 - ln));
        dq = dq << ln;
      end else if (ddr && lp && fl >= t - 4) begin
        dev_oe = 4'hf;
        dev_o = pq[31:28];
        pq = pq << 4;
      end else if (fl < t) dev_oe = 4'h0;
    end
    sk = sck;
  end
endmodule

// *** tb/test_flash_serial_phase_sequencer.sv ***
// bench: ahb register calls drive whole flash transfers, then compare
// assumes the device model on the pins; io wires are resolved here
`timescale 1ns/100ps
module test_flash_serial_phase_sequencer;
  localparam int          LIMIT = 20000;         // clocks before cut-off
  localparam logic [31:0] RD    = 32'hc3a5_96e1; // model read word
  localparam logic [31:0] LP    = 32'h5a3c_e187; // model pattern
  logic        clk_sys, nrst, hsel, hwrite, hreadyout, hresp;
  logic        m_q, m_rd, m_lp;
  logic [1:0]  htrans, m_w;
  logic [3:0]  io_w, flt, dev_o, dev_oe, m_lat;
  logic [6:0]  m_ib;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [63:0] rx;
  logic [3:0]  lats [4] = '{4'h3, 4'h2, 4'h0, 4'h6};
  int          error_cnt, compares, cyc;
  flash_phase_pkg::flash_pins_t pins;

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  flash_serial_phase_sequencer #(.SCK_HALF(6))
    i_flash_serial_phase_sequencer (.clk_sys(clk_sys), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pins(pins), .io_in(io_w));
  flash_device_model #(.RD_WORD(RD), .LP_WORD(LP)) i_flash_device_model (
    .sck(pins.sck), .cs_n(pins.cs_n), .io(io_w), .width(m_w), .qcmd(m_q),
    .rd(m_rd), .in_bits(m_ib), .lat(m_lat), .lp(m_lp), .dev_o(dev_o),
    .dev_oe(dev_oe), .rx(rx));

  // lines nobody drives wander, so a stale sample cannot match
  assign io_w = (pins.io_oe & pins.io_o) | (~pins.io_oe & dev_oe & dev_o)
              | (~pins.io_oe & ~dev_oe & flt);

  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) fail($sformatf("got %h want %h", g, e));
  endtask
  task automatic results;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // settings first, then go with the same value, wait for done or error
  task automatic run(input logic [31:0] ctl, cmd, adr, wd,
                     input logic [6:0] ib, input logic [31:0] st);
    {m_lp, m_q, m_rd, m_w} <= {ctl[12], ctl[4:1]};
    m_lat <= ctl[11:8];
    m_ib <= ib;
    bus(1'b1, flash_phase_pkg::OFF_CMD, cmd);
    bus(1'b1, flash_phase_pkg::OFF_ADDR, adr);
    bus(1'b1, flash_phase_pkg::OFF_WDATA, wd);
    bus(1'b1, flash_phase_pkg::OFF_CTRL, ctl);
    bus(1'b1, flash_phase_pkg::OFF_CTRL, ctl | 32'h1);
    do bus(1'b0, flash_phase_pkg::OFF_STATUS, 32'h0);
    while (q[0] !== 1'b0 || q[2:1] === 2'b00);
    cmp(q, st);
    bus(1'b1, flash_phase_pkg::OFF_STATUS, 32'h6);
  endtask

  // wandering lines, contention watch and the run's cut-off
  always @(posedge clk_sys) begin
    flt <= ~flt;
    cyc <= cyc + 1;
    if ((pins.io_oe & dev_oe) !== 4'h0) fail("both ends drive io");
    if (cyc == LIMIT) begin
      fail("timeout");
      results();
    end
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, nrst} = '0;
    {m_q, m_rd, m_lp, m_w, m_lat, m_ib} = '0;
    {error_cnt, compares, cyc} = '0;
    flt = 4'h5;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    // every word, the unmapped one too, reads zero after reset
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      cmp(q, 32'h0);
    end
    cmp({pins.cs_n, pins.io_oe, pins.io_o}, {1'b1, 8'hcc});
    // plain write of data only, then four-wire write with address
    run(32'h0004_0000, 32'ha7, 32'h0, 32'h9ab1_4c27, 7'd40, 32'h2);
    cmp(rx, {24'h0, 8'ha7, 32'h9ab1_4c27});
    run(32'h0004_0030, 32'h6e, 32'h12_34d8, 32'h5f08_e3b6, 7'd64, 32'h2);
    cmp(rx, {8'h6e, 24'h12_34d8, 32'h5f08_e3b6});
    cmp(pins.cs_n, 1'b1);
    // one read per width; latency codes differ so a wrong count shows
    for (int i = 0; i < 4; i++) begin
      run(32'h0004_0028 | (i << 1) | (lats[i] << 8) | ((i == 3) << 12),
          32'h5deb, 32'h7c_0316, 32'h0, (i == 0) ? 7'd32 : 7'd40, 32'h2);
      bus(1'b0, flash_phase_pkg::OFF_RDATA, 32'h0);
      cmp(q, RD);
      cmp(rx, (i == 0) ? {32'h0, 8'heb, 24'h7c_0316}
                       : {24'h0, 8'heb, 24'h7c_0316, 8'h5d});
    end
    bus(1'b0, flash_phase_pkg::OFF_PATTERN, 32'h0);
    cmp(q, LP);
    // pattern with only four latency cycles: refused, no frame sent
    run(32'h0004_142e, 32'h5deb, 32'h0, 32'h0, 7'd40, 32'h4);
    cmp(rx, {24'h0, 8'heb, 24'h7c_0316, 8'h5d});
    results();
  end
endmodule
